// *** logic/bfch_defines.vh ***
/*
  Shared codes, frame sizes and flash engine operations of the boot
  flash command handler.
  Assumes a plain Verilog-2005 flow that includes this file by bare name.
*/
// Functional notes
// - program ack, or D0 with 11/2A/53
// - all-FF address ends programming, back to selection
// - erase select loads routine, C8 54 on failure
// - erase frame: 58, size 1, block, sum
// - erase errors D8 with 11/12/29/51
// - block FF stops erasing, ack, selection
// - read frame: 52, size 9, area, addr, length
// - area 00 boot, 01 user, else address error
// - read reply: 52, length, data, sum
// - read errors D2 with 11/12/2A/2B
// - 4A returns 5A, 4, boot area sum
// - 4B returns 5B, 4, user area sum
// - 4C ack if boot area blank, else CC 52
// - 4D ack if user area blank, else CD 52
// - 4F always answered: 5F, 2, state, error
// - error byte 0 normally, 1 after error
// - state byte encodes current wait state
// - bad command answered 80 and command
`ifndef BFCH_DEFINES_VH
`define BFCH_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_PSEL_UB 8'h42
`define CMD_PSEL_UA 8'h43
`define CMD_ESEL 8'h48
`define CMD_PROG 8'h50
`define CMD_ERASE 8'h58
`define CMD_READ 8'h52
`define CMD_SUM_UB 8'h4a
`define CMD_SUM_UA 8'h4b
`define CMD_BLK_UB 8'h4c
`define CMD_BLK_UA 8'h4d
`define CMD_STAT 8'h4f

// ----------------------------------------
// Response and error codes
// ----------------------------------------
`define RSP_ACK 8'h06
`define RSP_CMDERR 8'h80
`define RSP_ERRBIT 8'h80
`define RSP_SUM_UB 8'h5a
`define RSP_SUM_UA 8'h5b
`define RSP_STAT 8'h5f
`define E_SUM 8'h11
`define E_SIZE 8'h12
`define E_BLK 8'h29
`define E_ADDR 8'h2a
`define E_LEN 8'h2b
`define E_ERASE 8'h51
`define E_BLANK 8'h52
`define E_PROG 8'h53
`define E_SEL 8'h54

// ----------------------------------------
// Wait state codes and frame constants
// ----------------------------------------
`define ST_SEL 8'h3f
`define ST_PRG 8'h4f
`define ST_ERS 8'h5f
`define END_ADDR 32'hffffffff
`define STOP_BLK 8'hff
`define BLANK_BYTE 8'hff
`define SZ_ERASE 8'h01
`define SZ_READ 8'h09
`define SZ_SUM 8'h04
`define SZ_STAT 8'h02
`define PAY_PADDR 8'h04
`define PAY_ERASE 8'h03
`define PAY_READ 8'h0b

// ----------------------------------------
// Flash engine operations
// ----------------------------------------
`define OP_LOAD 3'h0
`define OP_FILL 3'h1
`define OP_PROG 3'h2
`define OP_ERASE 3'h3
`define OP_READ 3'h4
`define OP_FIN 3'h5

`endif

// *** logic/bfch_acc.v ***
/*
  Byte accumulator used for frame checksums and area sums.
  Assumes inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
module bfch_acc #(
  parameter W = 8
) (
  input wire i_clk,        // Core clock
  input wire i_rst,        // Async reset, high
  input wire i_clr,        // Restart, loads byte if i_en
  input wire i_en,         // Add byte
  input wire [7:0] i_byte, // Byte to add
  output reg [W-1:0] o_sum // Running total
);

  // Clear wins so a frame's first byte seeds the sum
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sum <= {W{1'b0}};
    end else if (i_clr) begin
      o_sum <= i_en ? {{(W-8){1'b0}}, i_byte} : {W{1'b0}};
    end else if (i_en) begin
      o_sum <= o_sum + {{(W-8){1'b0}}, i_byte};
    end
  end

endmodule

// *** logic/bfch_range.v ***
/*
  Area range check for program and read requests.
  Assumes area bases and sizes are fixed at build time.
*/
`timescale 1ns/100ps
module bfch_range #(
  parameter [31:0] UB_BASE = 32'h00000000,
  parameter [31:0] UB_SIZE = 32'h00002000,
  parameter [31:0] UA_BASE = 32'h00100000,
  parameter [31:0] UA_SIZE = 32'h00100000
) (
  input wire i_ua,         // 1 selects user area
  input wire [31:0] i_start, // First byte address
  input wire [31:0] i_len, // Byte count
  output wire o_addr_ok,   // Start inside area
  output wire o_len_ok     // Whole run inside area
);

  wire [31:0] base = i_ua ? UA_BASE : UB_BASE;
  wire [31:0] size = i_ua ? UA_SIZE : UB_SIZE;
  wire [31:0] off = i_start - base;

  // Offset form avoids overflow of start plus length
  assign o_addr_ok = (i_start >= base) && (off < size);
  assign o_len_ok = o_addr_ok && (i_len <= size - off);

endmodule

// *** logic/bfch_top.v ***
/*
  Boot flash command handler: takes framed command bytes, drives a
  flash engine through a request/done handshake and sends replies.
  Assumes byte streams and flash engine share I_MCLK; the engine
  holds page bytes given by fill operations until a program op.
*/
`timescale 1ns/100ps
`include "bfch_defines.vh"
module bfch_top #(
  parameter [31:0] UB_BASE = 32'h00000000,
  parameter [31:0] UB_SIZE = 32'h00002000,
  parameter [31:0] UA_BASE = 32'h00100000,
  parameter [31:0] UA_SIZE = 32'h00100000,
  parameter [7:0] NBLK = 8'h10,
  parameter PAGE = 128
) (
  input wire I_MCLK,          // Core clock
  input wire I_RST,           // Async reset, high
  input wire [7:0] I_RX_DATA, // Host byte in
  input wire I_RX_VALID,      // Host byte present
  output wire O_RX_READY,     // Byte accepted
  output wire [7:0] O_TX_DATA, // Reply byte
  output wire O_TX_VALID,     // Reply byte present
  input wire I_TX_READY,      // Reply byte taken
  output wire O_FL_REQ,       // Engine request
  output wire [2:0] O_FL_OP,  // Engine operation
  output wire [31:0] O_FL_ADDR, // Address, block or id
  output wire [7:0] O_FL_WDATA, // Fill byte
  input wire I_FL_DONE,       // Engine done pulse
  input wire I_FL_ERR,        // Failure, with done
  input wire [7:0] I_FL_RDATA, // Read byte, with done
  output wire O_ERR_STATUS    // Error seen since reset
);

  // ----------------------------------------
  // States and modes
  // ----------------------------------------
  localparam S_CMD = 3'd0;
  localparam S_PAY = 3'd1;
  localparam S_EXEC = 3'd2;
  localparam S_FILL = 3'd3;
  localparam S_FLOP = 3'd4;
  localparam S_SCAN = 3'd5;
  localparam S_TX = 3'd6;
  localparam M_SEL = 2'd0;
  localparam M_PRG = 2'd1;
  localparam M_ERS = 2'd2;
  localparam [7:0] PAGE_LAST = PAGE - 1;
  localparam [7:0] PAGE_PAY = PAGE + 1;

  reg [2:0] st_q;
  reg [1:0] mode_q;
  reg parea_q;
  reg err_q;
  reg [7:0] cmd_q;
  reg [7:0] cnt_q;
  reg [7:0] need_q;
  reg [7:0] size_q;
  reg [7:0] arg_q;
  reg [31:0] addr_q;
  reg [31:0] len_q;
  reg [31:0] ptr_q;
  reg [31:0] left_q;
  reg blank_q;
  reg rd_q;
  reg [55:0] rsp_q;
  reg [2:0] rn_q;
  reg addsum_q;
  reg rx_rdy_q;
  reg [7:0] tx_data_q;
  reg tx_vld_q;
  reg fl_req_q;
  reg [2:0] fl_op_q;
  reg [31:0] fl_addr_q;
  reg [7:0] fl_wdata_q;
  reg [7:0] page [0:PAGE-1];

  wire [7:0] rx_sum;
  wire [7:0] tx_sum;
  wire [31:0] scan_sum;
  wire addr_ok;
  wire len_ok;

  assign O_RX_READY = rx_rdy_q;
  assign O_TX_DATA = tx_data_q;
  assign O_TX_VALID = tx_vld_q;
  assign O_FL_REQ = fl_req_q;
  assign O_FL_OP = fl_op_q;
  assign O_FL_ADDR = fl_addr_q;
  assign O_FL_WDATA = fl_wdata_q;
  assign O_ERR_STATUS = err_q;

  // ----------------------------------------
  // Decodes
  // ----------------------------------------
  wire rx_take = I_RX_VALID & rx_rdy_q;
  wire tx_take = tx_vld_q & I_TX_READY;
  wire is_prog = (cmd_q == `CMD_PROG);
  wire is_ua = (cmd_q == `CMD_SUM_UA) | (cmd_q == `CMD_BLK_UA);
  wire is_blank = (cmd_q == `CMD_BLK_UB) | (cmd_q == `CMD_BLK_UA);
  wire [7:0] pidx = cnt_q - `PAY_PADDR;
  wire [31:0] rx_addr = {addr_q[23:0], I_RX_DATA};
  wire fl_done = fl_req_q & I_FL_DONE;
  wire [7:0] tx_chk = (~tx_sum) + 8'h01;
  wire [7:0] state_code = (mode_q == M_PRG) ? `ST_PRG :
                          (mode_q == M_ERS) ? `ST_ERS : `ST_SEL;
  wire [7:0] err_rsp = cmd_q | `RSP_ERRBIT;

  // ----------------------------------------
  // Checksums and range checks
  // ----------------------------------------
  // incoming frame sum
  bfch_acc #(.W(8)) u_rx_sum (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_clr(st_q == S_CMD),
    .i_en(rx_take),
    .i_byte(I_RX_DATA),
    .o_sum(rx_sum)
  );

  bfch_acc #(.W(8)) u_tx_sum (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_clr(st_q == S_EXEC),
    .i_en(tx_take),
    .i_byte(tx_data_q),
    .o_sum(tx_sum)
  );

  bfch_acc #(.W(32)) u_scan_sum (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_clr(st_q == S_EXEC),
    .i_en(fl_done & ~rd_q & (fl_op_q == `OP_READ)),
    .i_byte(I_FL_RDATA),
    .o_sum(scan_sum)
  );

  bfch_range #(
    .UB_BASE(UB_BASE),
    .UB_SIZE(UB_SIZE),
    .UA_BASE(UA_BASE),
    .UA_SIZE(UA_SIZE)
  ) u_range (
    .i_ua(is_prog ? parea_q : arg_q[0]),
    .i_start(addr_q),
    .i_len(is_prog ? PAGE : len_q),
    .o_addr_ok(addr_ok),
    .o_len_ok(len_ok)
  );

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  // No reset: contents are always rewritten before use
  always @(posedge I_MCLK) begin
    if (rx_take && st_q == S_PAY && is_prog && cnt_q >= `PAY_PADDR && need_q > 8'h01) begin
      page[pidx[6:0]] <= I_RX_DATA;
    end
  end

  // ----------------------------------------
  // Reply helpers
  // ----------------------------------------
  task reply;
    input [55:0] b;
    input [2:0] n;
    input s;
    begin
      rsp_q <= b;
      rn_q <= n;
      addsum_q <= s;
      st_q <= S_TX;
    end
  endtask

  // any error reply latches the flag
  task fail;
    input [7:0] code;
    begin
      reply({err_rsp, code, 40'h0}, 3'd2, 1'b0);
      err_q <= 1'b1;
    end
  endtask

  task flop;
    input [2:0] op;
    input [31:0] a;
    begin
      fl_req_q <= 1'b1;
      fl_op_q <= op;
      fl_addr_q <= a;
      st_q <= S_FLOP;
    end
  endtask

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      st_q <= S_CMD;
      mode_q <= M_SEL;
      parea_q <= 1'b0;
      err_q <= 1'b0;
      cmd_q <= 8'h00;
      cnt_q <= 8'h00;
      need_q <= 8'h00;
      size_q <= 8'h00;
      arg_q <= 8'h00;
      addr_q <= 32'h0;
      len_q <= 32'h0;
      ptr_q <= 32'h0;
      left_q <= 32'h0;
      blank_q <= 1'b1;
      rd_q <= 1'b0;
      rsp_q <= 56'h0;
      rn_q <= 3'd0;
      addsum_q <= 1'b0;
      rx_rdy_q <= 1'b1;
      tx_data_q <= 8'h00;
      tx_vld_q <= 1'b0;
      fl_req_q <= 1'b0;
      fl_op_q <= `OP_LOAD;
      fl_addr_q <= 32'h0;
      fl_wdata_q <= 8'h00;
    end else begin
      case (st_q)
        // Command byte; payload length set by command
        S_CMD: begin
          if (rx_take) begin
            cmd_q <= I_RX_DATA;
            cnt_q <= 8'h00;
            rd_q <= 1'b0;
            if (I_RX_DATA == `CMD_PROG) begin
              need_q <= `PAY_PADDR;
              st_q <= S_PAY;
            end else if (I_RX_DATA == `CMD_ERASE) begin
              need_q <= `PAY_ERASE;
              st_q <= S_PAY;
            end else if (I_RX_DATA == `CMD_READ) begin
              need_q <= `PAY_READ;
              st_q <= S_PAY;
            end else begin
              // hold off host until reply sent
              rx_rdy_q <= 1'b0;
              st_q <= S_EXEC;
            end
          end
        end
        S_PAY: begin
          if (rx_take) begin
            cnt_q <= cnt_q + 8'h01;
            need_q <= need_q - 8'h01;
            if (cnt_q == 8'h00) begin
              size_q <= I_RX_DATA;
            end
            if (cnt_q == 8'h01) begin
              arg_q <= I_RX_DATA;
            end
            if (is_prog ? cnt_q < `PAY_PADDR : (cnt_q >= 8'h02 && cnt_q < 8'h06)) begin
              addr_q <= rx_addr;
            end
            // Sum byte must not shift into the length
            if (!is_prog && cnt_q >= 8'h06 && cnt_q < `PAY_READ - 8'h01) begin
              len_q <= {len_q[23:0], I_RX_DATA};
            end
            if (is_prog && cnt_q == 8'h03) begin
              need_q <= (rx_addr == `END_ADDR) ? 8'h01 : PAGE_PAY;
            end else if (need_q == 8'h01) begin
              rx_rdy_q <= 1'b0;
              st_q <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          ptr_q <= is_ua ? UA_BASE : UB_BASE;
          left_q <= is_ua ? UA_SIZE : UB_SIZE;
          blank_q <= 1'b1;
          cnt_q <= 8'h00;
          if (cmd_q == `CMD_STAT) begin
            reply({`RSP_STAT, `SZ_STAT, state_code, 7'h0, err_q, 24'h0}, 3'd4, 1'b1);
          end else if (cmd_q == `CMD_PSEL_UB || cmd_q == `CMD_PSEL_UA || cmd_q == `CMD_ESEL) begin
            if (mode_q == M_SEL) begin
              flop(`OP_LOAD, {24'h0, cmd_q});
            end else begin
              fail(cmd_q);
            end
          end else if (is_prog && mode_q == M_PRG) begin
            if (rx_sum != 8'h00) begin
              fail(`E_SUM);
            end else if (addr_q == `END_ADDR) begin
              flop(`OP_FIN, addr_q);
            end else if (!addr_ok || !len_ok) begin
              fail(`E_ADDR);
            end else begin
              st_q <= S_FILL;
            end
          end else if (cmd_q == `CMD_ERASE && mode_q == M_ERS) begin
            if (rx_sum != 8'h00) begin
              fail(`E_SUM);
            end else if (size_q != `SZ_ERASE) begin
              fail(`E_SIZE);
            end else if (arg_q == `STOP_BLK) begin
              mode_q <= M_SEL;
              reply({`RSP_ACK, 48'h0}, 3'd1, 1'b0);
            end else if (arg_q >= NBLK) begin
              fail(`E_BLK);
            end else begin
              flop(`OP_ERASE, {24'h0, arg_q});
            end
          end else if (cmd_q == `CMD_READ && mode_q == M_SEL) begin
            if (rx_sum != 8'h00) begin
              fail(`E_SUM);
            end else if (size_q != `SZ_READ) begin
              fail(`E_SIZE);
            end else if (arg_q > 8'h01 || !addr_ok) begin
              fail(`E_ADDR);
            end else if (!len_ok) begin
              fail(`E_LEN);
            end else begin
              rd_q <= 1'b1;
              ptr_q <= addr_q;
              left_q <= len_q;
              reply({`CMD_READ, len_q, 16'h0}, 3'd5, 1'b1);
            end
          end else if (cmd_q >= `CMD_SUM_UB && cmd_q <= `CMD_BLK_UA && mode_q == M_SEL) begin
            st_q <= S_SCAN;
          end else begin
            reply({`RSP_CMDERR, cmd_q, 40'h0}, 3'd2, 1'b0);
            err_q <= 1'b1;
          end
        end
        // One fill op per page byte, then program; request drops between ops
        S_FILL: begin
          if (cnt_q > PAGE_LAST) begin
            flop(`OP_PROG, addr_q);
          end else begin
            fl_wdata_q <= page[cnt_q[6:0]];
            flop(`OP_FILL, addr_q + {24'h0, cnt_q});
          end
        end
        S_FLOP: begin
          if (fl_done) begin
            fl_req_q <= 1'b0;
            case (fl_op_q)
              `OP_LOAD: begin
                if (I_FL_ERR) begin
                  fail(`E_SEL);
                end else begin
                  mode_q <= (cmd_q == `CMD_ESEL) ? M_ERS : M_PRG;
                  parea_q <= (cmd_q == `CMD_PSEL_UA);
                  reply({`RSP_ACK, 48'h0}, 3'd1, 1'b0);
                end
              end
              `OP_FILL: begin
                if (I_FL_ERR) begin
                  fail(`E_PROG);
                end else begin
                  cnt_q <= cnt_q + 8'h01;
                  st_q <= S_FILL;
                end
              end
              `OP_READ: begin
                if (rd_q) begin
                  reply({I_FL_RDATA, 48'h0}, 3'd1, addsum_q);
                end else begin
                  blank_q <= blank_q & (I_FL_RDATA == `BLANK_BYTE);
                  st_q <= S_SCAN;
                end
              end
              `OP_ERASE: begin
                if (I_FL_ERR) begin
                  fail(`E_ERASE);
                end else begin
                  reply({`RSP_ACK, 48'h0}, 3'd1, 1'b0);
                end
              end
              default: begin
                if (fl_op_q == `OP_FIN) begin
                  mode_q <= M_SEL;
                end
                if (I_FL_ERR) begin
                  fail(`E_PROG);
                end else begin
                  reply({`RSP_ACK, 48'h0}, 3'd1, 1'b0);
                end
              end
            endcase
          end
        end
        // walk area, then sum or blank verdict
        S_SCAN: begin
          if (left_q != 32'h0) begin
            ptr_q <= ptr_q + 32'h1;
            left_q <= left_q - 32'h1;
            flop(`OP_READ, ptr_q);
          end else if (!is_blank) begin
            reply({is_ua ? `RSP_SUM_UA : `RSP_SUM_UB, `SZ_SUM, scan_sum, 8'h0}, 3'd6, 1'b1);
          end else if (blank_q) begin
            reply({`RSP_ACK, 48'h0}, 3'd1, 1'b0);
          end else begin
            fail(`E_BLANK);
          end
        end
        // Send queued bytes, then read data, then sum
        S_TX: begin
          if (tx_take) begin
            tx_vld_q <= 1'b0;
          end else if (!tx_vld_q) begin
            if (rn_q != 3'd0) begin
              tx_data_q <= rsp_q[55:48];
              tx_vld_q <= 1'b1;
              rsp_q <= {rsp_q[47:0], 8'h0};
              rn_q <= rn_q - 3'd1;
            end else if (rd_q && left_q != 32'h0) begin
              ptr_q <= ptr_q + 32'h1;
              left_q <= left_q - 32'h1;
              flop(`OP_READ, ptr_q);
            end else if (addsum_q) begin
              tx_data_q <= tx_chk;
              tx_vld_q <= 1'b1;
              addsum_q <= 1'b0;
            end else begin
              rx_rdy_q <= 1'b1;
              st_q <= S_CMD;
            end
          end
        end
        default: begin
          st_q <= S_CMD;
          rx_rdy_q <= 1'b1;
        end
      endcase
    end
  end

endmodule

// *** verif/bfch_flash_model.sv ***
/*
  Behavioural flash engine facing the command handler.
  Assumes requests are held until the done pulse, one clock domain.
*/
`timescale 1ns/100ps
module bfch_flash_model (
  input wire logic i_clk,          // Core clock
  input wire logic i_rst,          // Async reset, high
  input wire logic i_req,          // Engine request
  input wire logic [31:0] i_addr,  // Byte address or block
  input wire logic i_fail,         // Bench asks for a failure
  input wire logic i_blank,        // Bench asks for erased cells
  output logic o_done,             // One-cycle completion
  output logic o_err,              // Failure, valid with done
  output logic [7:0] o_rdata       // Read byte, valid with done
);
  logic [1:0] cnt_q;
  logic [1:0] lat_q;
  // ----------------------------------------
  // Request service
  // ----------------------------------------
  // Random latency; off the done cycle the result lines churn
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 2'h0;
      lat_q <= 2'h1;
      o_done <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_done <= 1'b0;
      o_err <= ~o_err;
      o_rdata <= ~o_rdata;
      if (i_req && !o_done) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == lat_q) begin
          cnt_q <= 2'h0;
          lat_q <= 2'($urandom_range(0, 3));
          o_done <= 1'b1;
          o_err <= i_fail;
          o_rdata <= i_blank ? 8'hff : (i_addr[7:0] ^ i_addr[15:8] ^ 8'h3c);
        end
      end
    end
  end
endmodule

// *** verif/bfch_top_monitor.sv ***
/*
  Checker for the boot flash command handler top module.
  Assumes it is bound onto the top module and sees its ports only.
*/
`timescale 1ns/100ps
module bfch_top_monitor (
  input wire logic I_MCLK,          // Core clock
  input wire logic I_RST,           // Async reset, high
  input wire logic [7:0] I_RX_DATA, // Host byte
  input wire logic I_RX_VALID,      // Host byte present
  input wire logic O_RX_READY,      // Byte accepted
  input wire logic [7:0] O_TX_DATA, // Reply byte
  input wire logic O_TX_VALID,      // Reply present
  input wire logic I_TX_READY,      // Reply taken
  input wire logic O_FL_REQ,        // Engine request
  input wire logic [2:0] O_FL_OP,   // Engine operation
  input wire logic [31:0] O_FL_ADDR, // Engine address
  input wire logic I_FL_DONE,       // Engine done
  input wire logic O_ERR_STATUS     // Sticky error
);
  logic first_q;
  logic [7:0] cmd_q;
  wire known = cmd_q inside {8'h42, 8'h43, 8'h48, 8'h50, 8'h58, 8'h52, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4f};
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  // First byte after a reply names the command
  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      first_q <= 1'b1;
      cmd_q <= 8'h00;
    end else if (!O_RX_READY) begin
      first_q <= 1'b1;
    end else if (I_RX_VALID && first_q) begin
      first_q <= 1'b0;
      cmd_q <= I_RX_DATA;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_reply_blocks_rx: assert property (O_TX_VALID |-> !O_RX_READY)
    else $error("host byte accepted during a reply");
  a_tx_byte_held: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
    else $error("reply byte changed before taken");
  a_tx_gap_idle: assert property (O_TX_VALID && I_TX_READY |=> !O_TX_VALID)
    else $error("no idle cycle after reply byte");
  a_req_held: assert property (O_FL_REQ && !I_FL_DONE |=> O_FL_REQ && $stable(O_FL_OP) && $stable(O_FL_ADDR))
    else $error("engine request changed before done");
  a_req_release: assert property (O_FL_REQ && I_FL_DONE |=> !O_FL_REQ)
    else $error("engine request kept after done");
  a_stat_reply: assert property ($fell(O_RX_READY) && cmd_q == 8'h4f |-> ##[1:8] (O_TX_VALID && O_TX_DATA == 8'h5f))
    else $error("state inquiry not answered");
  a_bad_cmd_reply: assert property ($fell(O_RX_READY) && !known |-> ##[1:8] (O_TX_VALID && O_TX_DATA == 8'h80))
    else $error("unknown command not refused");
  a_err_raise: assert property ($fell(O_RX_READY) && !known |-> ##[1:40] O_ERR_STATUS)
    else $error("error flag not raised");
  a_err_sticky: assert property (O_ERR_STATUS |=> O_ERR_STATUS)
    else $error("error flag cleared without reset");
endmodule

bind bfch_top bfch_top_monitor u_mon (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_RX_DATA(I_RX_DATA),
  .I_RX_VALID(I_RX_VALID), .O_RX_READY(O_RX_READY), .O_TX_DATA(O_TX_DATA), .O_TX_VALID(O_TX_VALID),
  .I_TX_READY(I_TX_READY), .O_FL_REQ(O_FL_REQ), .O_FL_OP(O_FL_OP), .O_FL_ADDR(O_FL_ADDR),
  .I_FL_DONE(I_FL_DONE), .O_ERR_STATUS(O_ERR_STATUS));

// *** verif/test_boot_flash_command_handler.sv ***
/*
  Self-checking bench for the boot flash command handler.
  Assumes the engine model answers every request; areas are shrunk.
*/
`timescale 1ns/100ps
module test_boot_flash_command_handler;
  logic clk = 0, rst = 1, rx_v = 0, tx_r = 0, fail = 0, blank = 0;
  logic [7:0] rx_d = 8'h00;
  wire rx_rdy, tx_v, req, done, ferr, err_st;
  wire [7:0] tx_d, rd;
  wire [2:0] op;
  wire [31:0] fa;
  int err_count = 0, num_checks = 0, cyc = 0;
  logic [7:0] fq[$], eq[$];
  logic [31:0] s32;
  logic [7:0] eb[5] = '{8'h03, 8'h10, 8'h03, 8'h05, 8'hff};
  logic [7:0] ec[5] = '{8'h06, 8'h29, 8'h11, 8'h51, 8'h06};
  // ----------------------------------------
  // Clock, design and engine
  // ----------------------------------------
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  bfch_top #(.UB_SIZE(32'h10), .UA_BASE(32'h100), .UA_SIZE(32'h100)) dut (.I_MCLK(clk), .I_RST(rst),
    .I_RX_DATA(rx_d), .I_RX_VALID(rx_v), .O_RX_READY(rx_rdy), .O_TX_DATA(tx_d), .O_TX_VALID(tx_v),
    .I_TX_READY(tx_r), .O_FL_REQ(req), .O_FL_OP(op), .O_FL_ADDR(fa), .O_FL_WDATA(),
    .I_FL_DONE(done), .I_FL_ERR(ferr), .I_FL_RDATA(rd), .O_ERR_STATUS(err_st));
  bfch_flash_model u_fl (.i_clk(clk), .i_rst(rst), .i_req(req), .i_addr(fa), .i_fail(fail),
    .i_blank(blank), .o_done(done), .o_err(ferr), .o_rdata(rd));
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      summarize;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] pat(input int a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task summarize;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Host byte held until the handler is ready
  task send(input logic [7:0] b);
    rx_d = b;
    rx_v = 1'b1;
    while (rx_rdy !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    @(posedge clk);
    #2;
  endtask
  task frame(input bit sum, input bit bad);
    logic [7:0] s;
    s = 8'h00;
    foreach (fq[i]) begin
      s = s - fq[i];
      send(fq[i]);
    end
    if (sum) send(s ^ {7'h00, bad});
    rx_v = 1'b0;
    rx_d = ~rx_d;
    fq.delete();
  endtask
  // Reply taken with random stalls
  task reply(input bit sum);
    logic [7:0] s;
    s = 8'h00;
    foreach (eq[i]) s = s - eq[i];
    if (sum) eq.push_back(s);
    foreach (eq[i]) begin
      while (tx_v !== 1'b1) begin
        @(posedge clk);
        #2;
      end
      repeat ($urandom_range(0, 2)) @(posedge clk);
      #2;
      tx_r = 1'b1;
      cmp(tx_d, eq[i]);
      @(posedge clk);
      #2;
      tx_r = 1'b0;
      @(posedge clk);
      #2;
    end
    eq.delete();
  endtask
  task txn(input bit sum, input bit bad, input logic [7:0] e0, input logic [7:0] e1);
    frame(sum, bad);
    if (e0 == 8'h06) eq = '{e0};
    else eq = '{e0, e1};
    reply(0);
  endtask
  task stat(input logic [7:0] st, input logic [7:0] er);
    fq = '{8'h4f};
    frame(0, 0);
    eq = '{8'h5f, 8'h02, st, er};
    reply(1);
  endtask
  task prog(input logic [31:0] a, input bit bad, input logic [7:0] e0, input logic [7:0] e1);
    fq = '{8'h50, a[31:24], a[23:16], a[15:8], a[7:0]};
    for (int k = 0; k < 128; k++) fq.push_back(k < 100 ? 8'($urandom) : 8'hff);
    txn(1, bad, e0, e1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    s32 = $urandom(39);
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    stat(8'h3f, 8'h00);
    fq = '{8'h50, 8'hff, 8'hff, 8'hff, 8'hff};
    txn(1, 0, 8'h80, 8'h50);
    fq = '{8'h77};
    txn(0, 0, 8'h80, 8'h77);
    stat(8'h3f, 8'h01);
    fq = '{8'h43};
    txn(0, 0, 8'h06, 8'h00);
    stat(8'h4f, 8'h01);
    prog(32'h180, 0, 8'h06, 8'h00);
    prog(32'h100, 1, 8'hd0, 8'h11);
    prog(32'h200, 0, 8'hd0, 8'h2a);
    fail = 1'b1;
    prog(32'h100, 0, 8'hd0, 8'h53);
    fail = 1'b0;
    fq = '{8'h50, 8'hff, 8'hff, 8'hff, 8'hff};
    txn(1, 0, 8'h06, 8'h00);
    stat(8'h3f, 8'h01);
    fq = '{8'h48};
    txn(0, 0, 8'h06, 8'h00);
    stat(8'h5f, 8'h01);
    for (int k = 0; k < 5; k++) begin
      fail = (k == 3);
      fq = '{8'h58, 8'h01, eb[k]};
      txn(1, k == 2, ec[k] == 8'h06 ? 8'h06 : 8'hd8, ec[k]);
    end
    fail = 1'b0;
    stat(8'h3f, 8'h01);
    fq = '{8'h58, 8'h01, 8'h03};
    txn(1, 0, 8'h80, 8'h58);
    fail = 1'b1;
    fq = '{8'h48};
    txn(0, 0, 8'hc8, 8'h54);
    fail = 1'b0;
    fq = '{8'h52, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
    frame(1, 0);
    eq = '{8'h52, 8'h00, 8'h00, 8'h00, 8'h04, 8'h3c, 8'h3d, 8'h3e, 8'h3f};
    reply(1);
    for (int k = 0; k < 3; k++) begin
      fq = '{8'h52, 8'h09, k == 0 ? 8'h02 : 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        k == 1 ? 8'h11 : 8'h04};
      txn(1, k == 2, 8'hd2, k == 0 ? 8'h2a : (k == 1 ? 8'h2b : 8'h11));
    end
    for (int k = 0; k < 2; k++) begin
      s32 = 0;
      for (int a = k * 256; a < (k ? 512 : 16); a++) s32 += 32'(pat(a));
      fq = '{8'h4a + k[7:0]};
      frame(0, 0);
      eq = '{8'h5a + k[7:0], 8'h04, s32[31:24], s32[23:16], s32[15:8], s32[7:0]};
      reply(1);
    end
    fq = '{8'h4c};
    txn(0, 0, 8'hcc, 8'h52);
    fq = '{8'h4d};
    txn(0, 0, 8'hcd, 8'h52);
    blank = 1'b1;
    fq = '{8'h4c};
    txn(0, 0, 8'h06, 8'h00);
    fq = '{8'h4d};
    txn(0, 0, 8'h06, 8'h00);
    summarize;
  end
endmodule
